/* src/tbc_burst_timer.sv */
`timescale 1ns/1ps
// ==========================================================
// burst and pause interval timer
module tbc_burst_timer
  import tbc_pkg::*;
#(
  parameter int BURST_LEN = BURST_CYCLES,
  parameter int CNT_W = BURST_CNT_W
) (
  // clock and synchronised reset
  input wire logic clk,
  input wire logic rstN,
  // control side
  tbc_timer_if.tmr tmr
);

  tbc_state_t state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] lastCount;
  logic longLatched;

  // terminal count, doubled in the long mode
  assign lastCount = longLatched ? CNT_W'((BURST_LEN * 2) - 1) : CNT_W'(BURST_LEN - 1);

  // sequencer: burst, then an equal pause
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state <= TBC_IDLE;
      count <= '0;
      longLatched <= 1'b0;
    end else begin
      unique case (state)
        TBC_IDLE: begin
          count <= '0;
          if (tmr.start) begin
            longLatched <= tmr.longMode; // length fixed for the whole burst
            state <= TBC_BURST;
          end
        end
        TBC_BURST: begin
          if (count == lastCount) begin
            count <= '0;
            state <= TBC_PAUSE;
          end else begin
            count <= count + 1'b1;
          end
        end
        TBC_PAUSE: begin
          if (count == lastCount) begin
            count <= '0;
            state <= TBC_IDLE;
          end else begin
            count <= count + 1'b1;
          end
        end
        default: state <= TBC_IDLE; // code 2'b10 is illegal
      endcase
    end
  end

  // one-cycle done pulse as the pause ends
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tmr.done <= 1'b0;
    end else begin
      tmr.done <= (state == TBC_PAUSE) && (count == lastCount);
    end
  end

  assign tmr.burstOn = (state == TBC_BURST);
  assign tmr.busy = (state != TBC_IDLE);

endmodule : tbc_burst_timer

/* src/tbc_pkg.sv */
package tbc_pkg;

  // ==========================================================
  // port and register geometry
  localparam int DATA_W = 4;
  localparam logic [3:0] REGA_RESET = 4'h0;
  localparam logic [3:0] REGB_RESET = 4'h0;
  localparam logic [3:0] TXD_RESET = 4'h0;
  localparam logic [3:0] RXD_RESET = 4'h0;

  // ==========================================================
  // control register a fields
  localparam int REGA_TONE_OUT = 0;
  localparam int REGA_CALL_PROG = 1;
  localparam int REGA_IRQ_EN = 2;
  localparam int REGA_REDIRECT = 3;

  // ==========================================================
  // control register b fields
  localparam int REGB_BURST_N = 0;
  localparam int REGB_TEST = 1;
  localparam int REGB_SINGLE = 2;
  localparam int REGB_COLUMN = 3;

  // ==========================================================
  // status register fields
  localparam int ST_IRQ = 0;
  localparam int ST_TX_READY = 1;
  localparam int ST_RX_FULL = 2;
  localparam int ST_STEER = 3;

  // register select line values
  localparam logic SEL_DATA = 1'b0;
  localparam logic SEL_CTRL = 1'b1;

  // ==========================================================
  // burst timing at a 100 ns clock
  localparam int CLK_PERIOD_NS = 100;
  localparam int BURST_TIME_US = 51000;
  localparam int BURST_CYCLES = BURST_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int BURST_CNT_W = 21;

  // ==========================================================
  // burst sequencer states, gray along idle-burst-pause
  typedef enum logic [1:0] {
    TBC_IDLE = 2'b00,
    TBC_BURST = 2'b01,
    TBC_PAUSE = 2'b11
  } tbc_state_t;

endpackage : tbc_pkg

/* src/tbc_timer_if.sv */
`timescale 1ns/1ps
// ==========================================================
// control to burst timer link
interface tbc_timer_if;
  logic start;
  logic longMode;
  logic burstOn;
  logic busy;
  logic done;

  modport ctl (output start, output longMode, input burstOn, input busy, input done);
  modport tmr (input start, input longMode, output burstOn, output busy, output done);
endinterface : tbc_timer_if

/* src/tbc_top.sv */
`timescale 1ns/1ps
// What this block does
// - burst mode in tone mode: 51 ms burst then equal 51 ms pause
// - after burst and pause, set transmitter ready in status
// - call progress plus burst mode doubles burst and pause to 102 ms
// - call progress mode blocks receive decoding; transmit only
// - reset selects tone-signalling mode and automatic burst mode
// - single-tone mode sends one low or high group tone
// - register a bit 0 enables tone output, burst or not
// - register a bit 1 picks tone mode or call progress filter
// - call progress with interrupt enabled shows detected tones on pin
// - interrupt mode pulls pin low on received pair or tx ready
// - register a bit 3 sends only the next control write to b
// - select 0: tx write, rx read; select 1: control write, status read
// - register b bit 0 low: tx write starts burst and pause
// - interrupt pin is open drain, only drives low
module tbc_top
  import tbc_pkg::*;
#(
  parameter int BURST_LEN = BURST_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic csN,
  input wire logic wrN,
  input wire logic rdN,
  input wire logic register_select_line,
  input wire logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0] dataOut,
  output logic [DATA_W-1:0] dataOeN,
  // receiver side
  input wire logic steeringIn,
  input wire logic [DATA_W-1:0] rxCodeIn,
  input wire logic cpToneIn,
  // tone generator side
  output logic toneOn,
  output logic [DATA_W-1:0] toneCode,
  output logic singleTone,
  output logic columnTone,
  output logic cpFilterOn,
  output logic decodeOn,
  // open-drain interrupt and call progress pin
  output logic interrupt_tone_pin_out,
  output logic interruptTonePinOeN
);

  // ==========================================================
  // reset release
  logic rstMeta;
  logic rstN;

  // async assert, clean release through two stages
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end

  // ==========================================================
  // access decode
  function automatic logic portActive(input logic cs, input logic strobe);
    portActive = !cs && !strobe;
  endfunction : portActive

  logic wrLevel;
  logic rdLevel;
  logic wrPrev;
  logic rdPrev;
  logic wrTake;
  logic rdTake;

  assign wrLevel = portActive(csN, wrN);
  assign rdLevel = portActive(csN, rdN);

  // edge detect so a long strobe acts once
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPrev <= 1'b0;
      rdPrev <= 1'b0;
    end else begin
      wrPrev <= wrLevel;
      rdPrev <= rdLevel;
    end
  end

  assign wrTake = wrLevel && !wrPrev;
  assign rdTake = rdLevel && !rdPrev;

  logic wrTx;
  logic wrCtrl;
  logic rdRx;
  logic rdStatus;

  assign wrTx = wrTake && (register_select_line == SEL_DATA);
  assign wrCtrl = wrTake && (register_select_line == SEL_CTRL);
  assign rdRx = rdTake && (register_select_line == SEL_DATA);
  assign rdStatus = rdTake && (register_select_line == SEL_CTRL);

  // ==========================================================
  // control registers
  logic [3:0] control_register_a;
  logic [3:0] control_register_b;
  logic redirectPending;

  // a and b share one address; the redirect covers one write only
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      control_register_a <= REGA_RESET;
      control_register_b <= REGB_RESET;
      redirectPending <= 1'b0;
    end else if (wrCtrl) begin
      if (redirectPending) begin
        control_register_b <= dataIn;
        redirectPending <= 1'b0;
      end else begin
        control_register_a <= dataIn;
        redirectPending <= dataIn[REGA_REDIRECT];
      end
    end
  end

  logic toneEnable;
  logic callProgress;
  logic irqEnable;
  logic burstMode;
  logic testMode;

  assign toneEnable = control_register_a[REGA_TONE_OUT];
  assign callProgress = control_register_a[REGA_CALL_PROG];
  assign irqEnable = control_register_a[REGA_IRQ_EN];
  assign burstMode = !control_register_b[REGB_BURST_N];
  // test mode only acts in tone-signalling mode
  assign testMode = control_register_b[REGB_TEST] && !callProgress;

  // ==========================================================
  // burst timer
  tbc_timer_if tmrLink ();
  logic [DATA_W-1:0] txData;

  // a write while a burst runs is dropped so timing stays exact
  assign tmrLink.start = wrTx && burstMode && !tmrLink.busy;
  assign tmrLink.longMode = callProgress;

  tbc_burst_timer #(
    .BURST_LEN(BURST_LEN),
    .CNT_W(BURST_CNT_W)
  ) uTimer (
    .clk(clk),
    .rstN(rstN),
    .tmr(tmrLink.tmr)
  );

  // transmit data register
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      txData <= TXD_RESET;
    end else if (wrTx && !(burstMode && tmrLink.busy)) begin
      txData <= dataIn;
    end
  end

  // ==========================================================
  // transmitter ready flag
  logic txReady;

  // set wins over a same-cycle clear
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      txReady <= 1'b1;
    end else if (tmrLink.done) begin
      txReady <= 1'b1;
    end else if (tmrLink.start) begin
      txReady <= 1'b0;
    end
  end

  // ==========================================================
  // receive path
  logic steerPrev;
  logic steerRise;
  logic [DATA_W-1:0] rxData;
  logic rxFull;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      steerPrev <= 1'b0;
    end else begin
      steerPrev <= steeringIn;
    end
  end

  // no decoding at all while call progress mode is on
  assign steerRise = steeringIn && !steerPrev && !callProgress;

  // latch the code on the steering edge
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rxData <= RXD_RESET;
    end else if (steerRise) begin
      rxData <= rxCodeIn;
    end
  end

  // full flag: new pair beats a same-cycle read
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rxFull <= 1'b0;
    end else if (steerRise) begin
      rxFull <= 1'b1;
    end else if (rdRx) begin
      rxFull <= 1'b0;
    end
  end

  // ==========================================================
  // interrupt flag
  logic irqEvent;
  logic irqFlag;

  // tx ready only counts in burst mode
  assign irqEvent = steerRise || (tmrLink.done && burstMode);

  // sticky, cleared by a status read; an event wins
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irqFlag <= 1'b0;
    end else if (irqEvent) begin
      irqFlag <= 1'b1;
    end else if (rdStatus) begin
      irqFlag <= 1'b0;
    end
  end

  // ==========================================================
  // interrupt / call progress pin
  logic pinLow;

  always_comb begin
    pinLow = 1'b0;
    if (callProgress) begin
      pinLow = irqEnable && !cpToneIn;
    end else if (testMode) begin
      pinLow = steerPrev; // inverted steering view
    end else begin
      pinLow = irqEnable && irqFlag;
    end
  end

  // registered enable; the data level is always low
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      interruptTonePinOeN <= 1'b1;
    end else begin
      interruptTonePinOeN <= !pinLow;
    end
  end

  assign interrupt_tone_pin_out = 1'b0;

  // ==========================================================
  // tone generator controls
  logic next_toneOn;

  // burst mode gates the enable with the burst window
  assign next_toneOn = toneEnable && (!burstMode || tmrLink.burstOn);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      toneOn <= 1'b0;
      toneCode <= TXD_RESET;
      singleTone <= 1'b0;
      columnTone <= 1'b0;
      cpFilterOn <= 1'b0;
      decodeOn <= 1'b1;
    end else begin
      toneOn <= next_toneOn;
      toneCode <= txData;
      singleTone <= control_register_b[REGB_SINGLE];
      columnTone <= control_register_b[REGB_COLUMN];
      cpFilterOn <= callProgress;
      decodeOn <= !callProgress;
    end
  end

  // ==========================================================
  // read data
  logic [DATA_W-1:0] statusWord;
  logic [DATA_W-1:0] next_dataOut;

  always_comb begin
    statusWord = '0;
    statusWord[ST_IRQ] = irqFlag;
    statusWord[ST_TX_READY] = txReady;
    statusWord[ST_RX_FULL] = rxFull;
    statusWord[ST_STEER] = steeringIn;
  end

  assign next_dataOut = (register_select_line == SEL_CTRL) ? statusWord : rxData;

  // sample on the read edge so the word is stable while strobe holds
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      dataOut <= '0;
    end else if (rdTake) begin
      dataOut <= next_dataOut;
    end
  end

  // per-bit bus drive while reading
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : gDataOe
      always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          dataOeN[gi] <= 1'b1;
        end else begin
          dataOeN[gi] <= !rdLevel;
        end
      end
    end
  endgenerate

endmodule : tbc_top

/* tb/tbc_cpu_model.sv */
`timescale 1ns/1ps
// ==========================================================
// processor side of the register port
module tbc_cpu_model
  import tbc_pkg::*;
(
  // clock
  input wire logic clk,
  // strobes and select
  output logic csN,
  output logic wrN,
  output logic rdN,
  output logic sel,
  // data bus halves
  output logic [DATA_W-1:0] dataIn,
  input wire logic [DATA_W-1:0] dataOut,
  input wire logic [DATA_W-1:0] dataOeN
);
  logic [DATA_W-1:0] drv = 4'h0;
  logic drvEn = 1'b0;

  initial begin
    csN = 1'b1;
    wrN = 1'b1;
    rdN = 1'b1;
    sel = 1'b0;
  end

  // a floating bus shows the inverse, so a stale value never matches
  assign dataIn = drvEn ? drv : (&dataOeN ? ~drv : dataOut);

  // one access: strobe held two cycles, then one idle cycle
  task automatic acc(input logic s, input logic r, input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    @(negedge clk);
    csN = 1'b0;
    sel = s;
    drv = d;
    drvEn = !r;
    rdN = !r;
    wrN = r;
    repeat (2) @(negedge clk);
    q = dataOut;
    csN = 1'b1;
    wrN = 1'b1;
    rdN = 1'b1;
    drvEn = 1'b0;
    @(negedge clk);
  endtask : acc
endmodule : tbc_cpu_model

/* tb/tbc_top_checker.sv */
`timescale 1ns/1ps
// ==========================================================
// port-level checks for the tone burst control block
module tbc_top_checker
  import tbc_pkg::*;
#(
  parameter int BURST_LEN = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic csN,
  input wire logic wrN,
  input wire logic rdN,
  input wire logic register_select_line,
  input wire logic [DATA_W-1:0] dataIn,
  input wire logic [DATA_W-1:0] dataOut,
  input wire logic [DATA_W-1:0] dataOeN,
  // receiver side
  input wire logic steeringIn,
  input wire logic [DATA_W-1:0] rxCodeIn,
  input wire logic cpToneIn,
  // tone generator side
  input wire logic toneOn,
  input wire logic [DATA_W-1:0] toneCode,
  input wire logic singleTone,
  input wire logic columnTone,
  input wire logic cpFilterOn,
  input wire logic decodeOn,
  // interrupt pin
  input wire logic interrupt_tone_pin_out,
  input wire logic interruptTonePinOeN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // strobe decodes; outputs may lag a taken strobe by one or two edges
  wire logic ctlWr = !csN && !wrN && register_select_line;
  wire logic datWr = !csN && !wrN && !register_select_line;
  wire logic rdAct = !csN && !rdN;

  property p_pin_low_only; !interruptTonePinOeN |-> interrupt_tone_pin_out == 1'b0; endproperty
  a_pin_low_only: assert property (p_pin_low_only) else $error("pin driven high");
  property p_decode_mode; decodeOn != cpFilterOn; endproperty
  a_decode_mode: assert property (p_decode_mode) else $error("decode on in call progress");
  property p_cp_quiet; cpFilterOn && $past(cpFilterOn) && $past(cpToneIn) |-> interruptTonePinOeN; endproperty
  a_cp_quiet: assert property (p_cp_quiet) else $error("pin low without tone");
  property p_read_oe; rdAct && !$past(rdAct) |=> dataOeN == 4'h0; endproperty
  a_read_oe: assert property (p_read_oe) else $error("read not driven");
  property p_oe_idle; !rdAct |=> dataOeN == 4'hf; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("bus driven while idle");
  property p_reset_vals;
    $rose(nrst) |-> !toneOn && decodeOn && !cpFilterOn && interruptTonePinOeN ##1 !toneOn && decodeOn;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad state after reset");
  property p_b_change; $changed({singleTone, columnTone}) |-> $past(ctlWr) || $past(ctlWr, 2); endproperty
  a_b_change: assert property (p_b_change) else $error("tone shape moved alone");
  property p_mode_change; $changed(cpFilterOn) |-> $past(ctlWr) || $past(ctlWr, 2); endproperty
  a_mode_change: assert property (p_mode_change) else $error("mode moved alone");
  property p_code_change; $changed(toneCode) |-> $past(datWr) || $past(datWr, 2); endproperty
  a_code_change: assert property (p_code_change) else $error("tone code moved alone");
endmodule : tbc_top_checker

bind tbc_top tbc_top_checker #(.BURST_LEN(BURST_LEN)) u_chk (.clk(clk), .nrst(nrst), .csN(csN), .wrN(wrN),
  .rdN(rdN), .register_select_line(register_select_line), .dataIn(dataIn), .dataOut(dataOut),
  .dataOeN(dataOeN), .steeringIn(steeringIn), .rxCodeIn(rxCodeIn), .cpToneIn(cpToneIn), .toneOn(toneOn),
  .toneCode(toneCode), .singleTone(singleTone), .columnTone(columnTone), .cpFilterOn(cpFilterOn),
  .decodeOn(decodeOn), .interrupt_tone_pin_out(interrupt_tone_pin_out),
  .interruptTonePinOeN(interruptTonePinOeN));

/* tb/test_tone_transceiver_burst_control.sv */
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the tone burst control block
module test_tone_transceiver_burst_control
  import tbc_pkg::*;
;
  // short burst keeps the run brief
  localparam int N = 20;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic csN, wrN, rdN, sel, toneOn, singleTone, columnTone, cpFilterOn, decodeOn, pinOut, pinOeN;
  logic steer = 1'b0;
  logic cpt = 1'b1;
  logic [3:0] rxc = 4'h0;
  logic [3:0] dataIn, dataOut, dataOeN, toneCode, q, code;
  logic [3:0] rxQ[$];
  int n_fail = 0;
  int tests_run = 0;
  int seed, n, i, expLen;

  tbc_top #(.BURST_LEN(N)) u_dut (.clk(clk), .nrst(nrst), .csN(csN), .wrN(wrN), .rdN(rdN),
    .register_select_line(sel), .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN),
    .steeringIn(steer), .rxCodeIn(rxc), .cpToneIn(cpt), .toneOn(toneOn), .toneCode(toneCode),
    .singleTone(singleTone), .columnTone(columnTone), .cpFilterOn(cpFilterOn), .decodeOn(decodeOn),
    .interrupt_tone_pin_out(pinOut), .interruptTonePinOeN(pinOeN));
  tbc_cpu_model u_cpu (.clk(clk), .csN(csN), .wrN(wrN), .rdN(rdN), .sel(sel), .dataIn(dataIn),
    .dataOut(dataOut), .dataOeN(dataOeN));

  initial begin
    forever #50 clk = ~clk;
  end

  // ==========================================================
  // helpers
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // cycles a level holds; bounded so a stuck output ends the run
  task automatic cnt(input bit pin, input logic v, output int c);
    for (c = 0; c < 300; c++) begin
      if ((pin ? pinOeN : toneOn) !== v) return;
      @(negedge clk);
    end
    n_fail++;
    $display("ERROR %0t wait ran out", $time);
    stop_test();
  endtask : cnt

  task automatic wr(input logic s, input logic [3:0] d);
    u_cpu.acc(s, 1'b0, d, q);
  endtask : wr

  task automatic rd(input logic s);
    u_cpu.acc(s, 1'b1, 4'h0, q);
  endtask : rd

  // ==========================================================
  // main sequence
  initial begin
    seed = 32'h5a0d66db;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    rd(SEL_CTRL);
    chk(q, 8'(1 << ST_TX_READY), "status at reset");
    // burst in tone mode, then doubled in call progress mode
    for (i = 0; i < 2; i++) begin
      expLen = N << i;
      wr(SEL_CTRL, i ? 4'h7 : 4'h5);
      chk(decodeOn, i == 0, "decode mode");
      code = 4'($random(seed));
      wr(SEL_DATA, code);
      chk(toneCode, code, "tone code");
      cnt(0, 1'b1, n);
      // the write task returns one cycle after the tone came on, so that cycle is not counted
      chk(n + 1, expLen, "burst length");
      cpt = 1'b0;
      cnt(1, 1'b1, n);
      chk(i ? n <= 2 : n >= N - 2 && n <= N + 1, 1'b1, "pin timing");
      cpt = 1'b1;
      repeat (expLen + 3) @(negedge clk);
      rd(SEL_CTRL);
      chk(q[ST_TX_READY], 1'b1, "tx ready");
      chk(pinOeN, 1'b1, "pin released");
    end
    // received pair pulls the pin low, then reads back on the data address
    wr(SEL_CTRL, 4'h4);
    rxc = 4'($random(seed));
    rxQ.push_back(rxc);
    @(negedge clk);
    steer = 1'b1;
    repeat (3) @(negedge clk);
    chk(pinOeN, 1'b0, "rx interrupt");
    rd(SEL_DATA);
    chk(q, rxQ.pop_front(), "rx code");
    steer = 1'b0;
    // one write redirected to b: burst off, single column tone
    wr(SEL_CTRL, 4'h9);
    wr(SEL_CTRL, 4'hd);
    chk({singleTone, columnTone}, 2'b11, "single tone");
    chk(toneOn, 1'b1, "free tone on");
    // processor times the tone itself by clearing the enable
    wr(SEL_CTRL, 4'h0);
    chk({toneOn, singleTone}, 2'b01, "back to a");
    // test mode through b, burst back on: pin shows the inverted steering level
    wr(SEL_CTRL, 4'h8);
    wr(SEL_CTRL, 4'h2);
    steer = 1'b1;
    repeat (3) @(negedge clk);
    chk(pinOeN, 1'b0, "test pin low");
    steer = 1'b0;
    repeat (3) @(negedge clk);
    chk(pinOeN, 1'b1, "test pin high");
    // a second data write inside a running burst is dropped
    code = 4'($random(seed));
    wr(SEL_DATA, code);
    wr(SEL_DATA, ~code);
    chk(toneCode, code, "busy write dropped");
    rd(SEL_CTRL);
    chk(q[ST_TX_READY], 1'b0, "tx busy");
    stop_test();
  end
endmodule : test_tone_transceiver_burst_control
